// file: src/sts_pkg.sv
// package: constants shared by the stepper serial port files
package sts_pkg;
    // ========================================
    // datagram layout
    localparam int          FRAME_BITS   = 40;
    localparam int          DATA_BITS    = 32;
    localparam int          ADDR_BITS    = 7;
    localparam int          STAT_BITS    = 8;
    localparam int          WR_BIT_POS   = 39;
    localparam int          ADDR_MSB_POS = 38;
    localparam int          ADDR_LSB_POS = 32;
    localparam int          STAT_LSB_POS = 32;
    // ========================================
    // reset values
    localparam logic [39:0] FRAME_RST    = 40'h00_0000_0000;
    localparam logic [31:0] DATA_RST     = 32'h0000_0000;
    localparam logic [6:0]  ADDR_RST     = 7'h00;
    // ========================================
    // timing
    localparam int          CLK_PERIOD_PS = 5000;
    localparam int          FILT_TIME_NS  = 20;
    localparam int          FILT_CYC      =
        (FILT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // ========================================
    // command sequencer states
    typedef enum logic [1:0] {
        STS_IDLE = 2'b00,
        STS_EXEC = 2'b01,
        STS_RESP = 2'b10
    } sts_seq_e;
endpackage : sts_pkg

// file: src/sts_flt_if.sv
// interface: one raw pin and its filtered level
`timescale 1ns/100ps
interface sts_flt_if;
    logic raw;
    logic filt;
    modport filter (input raw, output filt);
    modport user   (output raw, input filt);
endinterface : sts_flt_if

// file: src/sts_glitch_filter.sv
// module: two-flop synchroniser plus stability filter for one pin
`timescale 1ns/100ps
module sts_glitch_filter
    import sts_pkg::*;
#(
    parameter int        STABLE_CYC = FILT_CYC,
    parameter logic      RST_LEVEL  = 1'b1
) (
    // clock and reset
    input  wire logic    core_clk,
    input  wire logic    rst_n,
    // pin and level
    sts_flt_if.filter    pin
);
    localparam int CW = $clog2(STABLE_CYC + 1);
    // one sample beyond the filter time, so a pulse just under it never wins
    localparam logic [CW-1:0] CNT_LAST = CW'(STABLE_CYC);

    logic          sync1_reg;
    logic          sync2_reg;
    logic          filt_reg;
    logic [CW-1:0] cnt_reg;

    // ========================================
    // synchroniser
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_reg <= RST_LEVEL;
            sync2_reg <= RST_LEVEL;
        end else begin
            sync1_reg <= pin.raw;
            sync2_reg <= sync1_reg;
        end
    end

    // ========================================
    // level must stand the whole filter time before it is taken
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_reg  <= '0;
            filt_reg <= RST_LEVEL;
        end else if (sync2_reg == filt_reg) begin
            cnt_reg  <= '0;
        end else if (cnt_reg == CNT_LAST) begin
            cnt_reg  <= '0;
            filt_reg <= sync2_reg;
        end else begin
            cnt_reg  <= cnt_reg + CW'(1);
        end
    end

    assign pin.filt = filt_reg;
endmodule : sts_glitch_filter

// file: src/sts_spi_slave.sv
// module: serial slave port of the dual-axis stepper controller
`timescale 1ns/100ps
// Summary of operation
// - port acts only while chip select is low
// - data in sampled on rising clock, data out changes after falling clock
// - datagrams move most significant bit first
// - input bits reappear on the output 40 clocks later for chaining
// - rising chip select turns the shift register into one command
// - with surplus bits, the last 40 received form the command
// - pulses shorter than 20 ns on driver enable, and on chip select as seen by the command sequencer and output enable, cause no reaction
// - clock mode 3: idles high, drive on fall, capture on rise
// - command and answer regs clear at reset; pin levels reset high; shift register has no reset
// - register access classes and clear-on-read flags are left to the register file
// - 40-bit datagram: write bit 39, 7-bit address, 32 data bits
// - read data comes in next datagram; after a write, the write data echoes
// - eight status flags latched per access, returned in bits 39..32
module sts_spi_slave
    import sts_pkg::*;
(
    // system clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // serial link
    input  wire logic                 link_sck,
    input  wire logic                 chip_select_n,
    input  wire logic                 sdi,
    output wire logic                 sdo_o,
    output wire logic                 sdo_oe,
    // driver enable pin and its filtered level
    input  wire logic                 drv_enn,
    output wire logic                 drv_enn_filt,
    // command toward the register file
    output wire logic                 cmd_valid,
    output wire logic                 write_select_bit,
    output wire logic [ADDR_BITS-1:0] cmd_addr,
    output wire logic [DATA_BITS-1:0] cmd_wdata,
    // answer from the register file
    input  wire logic [DATA_BITS-1:0] rd_data,
    input  wire logic [STAT_BITS-1:0] status_flags
);
    // ========================================
    // decode helpers
    // true while a level is high and was low one cycle before
    function automatic logic level_rose(input logic now_lvl, input logic was_lvl);
        return now_lvl && !was_lvl;
    endfunction : level_rose

    // ========================================
    // link domain: shift register on the bus clock
    // tx word only moves while select is high and the bus clock stands still
    logic [FRAME_BITS-1:0] shift_reg;
    logic                  started_reg;
    logic                  fell_reg;
    logic                  sdo_q_reg;
    logic [FRAME_BITS-1:0] tx_word_reg;

    // chip select high clears the frame state; the bus clock is stopped then
    always_ff @(posedge link_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    // first edge loads the answer, later edges shift; msb leaves first
    always_ff @(posedge link_sck) begin
        if (!chip_select_n) begin
            if (!started_reg) begin
                shift_reg <= {tx_word_reg[FRAME_BITS-2:0], sdi};
            end else begin
                shift_reg <= {shift_reg[FRAME_BITS-2:0], sdi};
            end
        end
    end

    always_ff @(negedge link_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            fell_reg  <= 1'b0;
            sdo_q_reg <= 1'b0;
        end else begin
            fell_reg  <= 1'b1;
            if (!fell_reg) begin
                sdo_q_reg <= tx_word_reg[FRAME_BITS-1];
            end else begin
                sdo_q_reg <= shift_reg[FRAME_BITS-1];
            end
        end
    end

    // mode 3 leads with a falling edge, so the answer msb goes out there
    assign sdo_o = sdo_q_reg;

    // ========================================
    // pin filters in the system domain
    // the bus clock is the link clock itself, so it and data in are not filtered
    sts_flt_if cs_if ();
    sts_flt_if en_if ();

    assign cs_if.raw = chip_select_n;
    assign en_if.raw = drv_enn;

    sts_glitch_filter #(
        .STABLE_CYC (FILT_CYC),
        .RST_LEVEL  (1'b1)
    ) u_cs_filt (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin      (cs_if)
    );

    sts_glitch_filter #(
        .STABLE_CYC (FILT_CYC),
        .RST_LEVEL  (1'b1)
    ) u_en_filt (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin      (en_if)
    );

    // ========================================
    // command sequencer
    sts_seq_e              state_reg;
    logic                  cs_prev_reg;
    logic                  cmd_valid_reg;
    logic                  wr_reg;
    logic [ADDR_BITS-1:0]  addr_reg;
    logic [DATA_BITS-1:0]  wdata_reg;
    logic                  sdo_oe_reg;
    logic                  enn_reg;

    // ========================================
    // select edge and pin levels
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cs_prev_reg <= 1'b1;
        end else begin
            cs_prev_reg <= cs_if.filt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sdo_oe_reg <= 1'b0;
            enn_reg    <= 1'b1;
        end else begin
            sdo_oe_reg <= ~cs_if.filt;
            enn_reg    <= en_if.filt;
        end
    end

    // ========================================
    // sequencer state
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= STS_IDLE;
        end else begin
            unique case (state_reg)
                STS_IDLE: begin
                    if (level_rose(cs_if.filt, cs_prev_reg)) begin
                        state_reg <= STS_EXEC;
                    end
                end
                STS_EXEC: begin
                    state_reg <= STS_RESP;
                end
                STS_RESP: begin
                    state_reg <= STS_IDLE;
                end
                default: begin
                    state_reg <= STS_IDLE;
                end
            endcase
        end
    end

    // ========================================
    // command capture
    // shift register is still while chip select is high, so it is read here
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cmd_valid_reg <= 1'b0;
            wr_reg        <= 1'b0;
            addr_reg      <= ADDR_RST;
            wdata_reg     <= DATA_RST;
        end else if (state_reg == STS_IDLE && level_rose(cs_if.filt, cs_prev_reg)) begin
            cmd_valid_reg <= 1'b1;
            wr_reg        <= shift_reg[WR_BIT_POS];
            addr_reg      <= shift_reg[ADDR_MSB_POS:ADDR_LSB_POS];
            wdata_reg     <= shift_reg[DATA_BITS-1:0];
        end else begin
            cmd_valid_reg <= 1'b0;
        end
    end

    // ========================================
    // answer word
    // answer for the next frame: status plus read data or write echo
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_word_reg <= FRAME_RST;
        end else if (state_reg == STS_EXEC) begin
            tx_word_reg[FRAME_BITS-1:STAT_LSB_POS] <= status_flags;
            tx_word_reg[DATA_BITS-1:0] <= wr_reg ? wdata_reg : rd_data;
        end
    end

    // ========================================
    // outputs
    assign sdo_oe           = sdo_oe_reg;
    assign drv_enn_filt     = enn_reg;
    assign cmd_valid        = cmd_valid_reg;
    assign write_select_bit = wr_reg;
    assign cmd_addr         = addr_reg;
    assign cmd_wdata        = wdata_reg;
endmodule : sts_spi_slave

// file: dv/sts_spi_slave_asserts.sv
// checker: timing properties on the serial port pins
`timescale 1ns/100ps
module sts_spi_slave_asserts
    import sts_pkg::*;
(
    // clock and reset
    input wire logic                 core_clk,
    input wire logic                 rst_n,
    // link
    input wire logic                 link_sck,
    input wire logic                 chip_select_n,
    input wire logic                 sdi,
    input wire logic                 sdo_o,
    input wire logic                 sdo_oe,
    // driver enable
    input wire logic                 drv_enn,
    input wire logic                 drv_enn_filt,
    // command side
    input wire logic                 cmd_valid,
    input wire logic                 write_select_bit,
    input wire logic [ADDR_BITS-1:0] cmd_addr,
    input wire logic [DATA_BITS-1:0] cmd_wdata,
    input wire logic [DATA_BITS-1:0] rd_data,
    input wire logic [STAT_BITS-1:0] status_flags
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // run of high select samples; saturates so it never wraps into a false window
    logic [3:0] cs_hi_cnt;
    always_ff @(posedge core_clk) begin
        if (!rst_n || !chip_select_n) begin
            cs_hi_cnt <= 4'h0;
        end else if (cs_hi_cnt != 4'hF) begin
            cs_hi_cnt <= cs_hi_cnt + 4'h1;
        end
    end
    property p_rst;
        disable iff (1'b0) !rst_n |=> !cmd_valid && !sdo_oe && drv_enn_filt;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_cs_rise; cmd_valid |-> chip_select_n && $past(chip_select_n, 5); endproperty
    a_cs_rise: assert property (p_cs_rise) else $error("command without select rise");
    property p_hold; !cmd_valid |-> $stable({write_select_bit, cmd_addr, cmd_wdata}); endproperty
    a_hold: assert property (p_hold) else $error("command fields moved");
    property p_quiet; cs_hi_cnt >= 4'hC |-> !cmd_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("command while deselected");
    property p_oe_off; chip_select_n [*8] ##1 chip_select_n |=> !sdo_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("output not released");
    property p_oe_on; !chip_select_n [*8] ##1 !chip_select_n |=> sdo_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("output not driven");
    property p_filt;
        $stable(drv_enn) [*8] ##1 $stable(drv_enn) |-> drv_enn_filt == drv_enn;
    endproperty
    a_filt: assert property (p_filt) else $error("filtered enable stale");
    // a single core cycle is 5 ns, far under the filter time
    property p_glitch; $stable(drv_enn) [*8] ##1 $changed(drv_enn) ##1 $changed(drv_enn)
        |=> (drv_enn_filt == drv_enn) [*4]; endproperty
    a_glitch: assert property (p_glitch) else $error("glitch passed filter");
endmodule : sts_spi_slave_asserts
bind sts_spi_slave sts_spi_slave_asserts sts_spi_slave_asserts_inst (.*);

// file: dv/sts_host_model.sv
// model: host master for the serial port, clock mode 3
`timescale 1ns/100ps
module sts_host_model (
    // link pins
    output logic      link_sck,
    output logic      chip_select_n,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        link_sck = 1'b1;
        chip_select_n = 1'b1;
        sdi = 1'b0;
    end
    // 30 ns bit period, sck stands high outside frames
    task automatic xfer(input logic [55:0] tx, input int n, output logic [55:0] rx);
        rx = '0;
        chip_select_n = 1'b0;
        #40;
        for (int i = n - 1; i >= 0; i--) begin
            link_sck = 1'b0;
            sdi = tx[i];
            #15 link_sck = 1'b1;
            rx[i] = sdo;
            #15;
        end
        chip_select_n = 1'b1;
        sdi = ~sdi;
        #100;
    endtask : xfer
    // clocks while deselected, then a select pulse under the filter time
    task automatic noise();
        repeat (4) begin
            #15 link_sck = 1'b0;
            sdi = ~sdi;
            #15 link_sck = 1'b1;
        end
        chip_select_n = 1'b0;
        #6 chip_select_n = 1'b1;
        #100;
    endtask : noise
endmodule : sts_host_model

// file: dv/stepper_ctrl_spi_slave_test.sv
// testbench: serial port against a queued answer model
`timescale 1ns/100ps
module stepper_ctrl_spi_slave_test;
    import sts_pkg::*;
    logic                 core_clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 drv_enn = 1'b1;
    logic [DATA_BITS-1:0] rd_data = '0;
    logic [STAT_BITS-1:0] status_flags = '0;
    wire                  link_sck, chip_select_n, sdi, sdo_o, sdo_oe;
    wire                  drv_enn_filt, cmd_valid, write_select_bit;
    wire [ADDR_BITS-1:0]  cmd_addr;
    wire [DATA_BITS-1:0]  cmd_wdata;
    wire                  sdo_line = sdo_oe ? sdo_o : 1'bz;
    int                   err_count = 0;
    int                   num_checks = 0;
    int                   seed = 21710;
    int                   cyc = 0;
    int                   cmds = 0;
    int                   n, c0;
    logic [39:0]          ans_q[$];
    logic [39:0]          cmd;
    logic [55:0]          tx, rx;
    sts_spi_slave sts_spi_slave_inst (
        .core_clk         (core_clk),
        .rst_n            (rst_n),
        .link_sck         (link_sck),
        .chip_select_n    (chip_select_n),
        .sdi              (sdi),
        .sdo_o            (sdo_o),
        .sdo_oe           (sdo_oe),
        .drv_enn          (drv_enn),
        .drv_enn_filt     (drv_enn_filt),
        .cmd_valid        (cmd_valid),
        .write_select_bit (write_select_bit),
        .cmd_addr         (cmd_addr),
        .cmd_wdata        (cmd_wdata),
        .rd_data          (rd_data),
        .status_flags     (status_flags)
    );
    sts_host_model host_inst (.link_sck(link_sck), .chip_select_n(chip_select_n),
        .sdi(sdi), .sdo(sdo_line));
    always #2.5 core_clk = ~core_clk;
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [39:0] exp, input logic [39:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cmd_valid === 1'b1)
            cmds <= cmds + 1;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        ans_q.push_back(FRAME_RST);
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (10) @(negedge core_clk);
        for (int k = 0; k < 12; k++) begin
            @(negedge core_clk);
            rd_data = $random(seed);
            status_flags = 8'($random(seed));
            drv_enn = 1'($random(seed));
            cmd = {1'(k), 7'($random(seed)), 32'($random(seed))};
            n = (k == 6) ? 56 : 40;
            tx = {16'($random(seed)), cmd};
            c0 = cmds;
            host_inst.xfer(tx, n, rx);
            check(ans_q.pop_front(), rx[n-1 -: 40]);
            if (n == 56) check(40'(tx[55:40]), 40'(rx[15:0]));
            check(40'(cmds - c0), 40'h1);
            check({write_select_bit, cmd_addr, cmd_wdata}, cmd);
            ans_q.push_back({status_flags, cmd[39] ? cmd[31:0] : rd_data});
            drv_enn = ~drv_enn;
            @(negedge core_clk);
            drv_enn = ~drv_enn;
            repeat (10) begin
                @(negedge core_clk);
                check(40'(drv_enn_filt), 40'(drv_enn));
            end
            $display("frame %0d done", k);
        end
        c0 = cmds;
        host_inst.noise();
        check(40'(cmds - c0), 40'h0);
        $display("noise done");
        report_and_stop();
    end
endmodule : stepper_ctrl_spi_slave_test
